// *** rtl/prc_pg_delay.v ***
// Purpose: Power-good rising-edge delay with selectable length
// Assumes: raw power-good is synchronous to clk
// Notes:   Falling edge passes through in one cycle
`timescale 1ns/10ps
`include "prc_regs.vh"
module prc_pg_delay #(
  parameter [31:0] DLY0 = `PRC_PG_DLY0_MS * `PRC_MS_CYCLES,
  parameter [31:0] DLY1 = `PRC_PG_DLY1_MS * `PRC_MS_CYCLES,
  parameter [31:0] DLY2 = `PRC_PG_DLY2_MS * `PRC_MS_CYCLES,
  parameter [31:0] DLY3 = `PRC_PG_DLY3_MS * `PRC_MS_CYCLES
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [1:0] delay_sel,
  input  wire       pg_raw,
  output reg        pg_out
);

  reg  [31:0] count;
  reg  [31:0] limit;

  always @*
  begin
    case (delay_sel)
      2'b00:   limit = DLY0;
      2'b01:   limit = DLY1;
      2'b10:   limit = DLY2;
      default: limit = DLY3;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count  <= 32'h0000_0000;
      pg_out <= 1'b0;
    end
    else if (!pg_raw)
    begin
      // Falls immediately, no delay on the way down
      count  <= 32'h0000_0000;
      pg_out <= 1'b0;
    end
    else if (!pg_out)
    begin
      if (count + 32'h0000_0001 >= limit)
        pg_out <= 1'b1;
      else
        count <= count + 32'h0000_0001;
    end
  end

endmodule // prc_pg_delay

// *** rtl/prc_rail_ctrl.v ***
// Purpose: Rail enable, suspend flag and configuration register bank of a power manager
// Assumes: serial bus front end delivers one-cycle read/write strobes with subaddress
// Notes:   Sequencer, seal state and power state arrive as synchronous inputs
`timescale 1ns/10ps
`include "prc_regs.vh"
module prc_rail_ctrl #(
  parameter [7:0]  KEY_VALUE  = `PRC_KEY_VALUE,
  parameter [39:0] PB_SHORT   = `PRC_PB_SHORT_S * `PRC_CLK_HZ,
  parameter [39:0] PB_LONG    = `PRC_PB_LONG_S * `PRC_CLK_HZ,
  parameter [31:0] PG_DLY0    = `PRC_PG_DLY0_MS * `PRC_MS_CYCLES,
  parameter [31:0] PG_DLY1    = `PRC_PG_DLY1_MS * `PRC_MS_CYCLES,
  parameter [31:0] PG_DLY2    = `PRC_PG_DLY2_MS * `PRC_MS_CYCLES,
  parameter [31:0] PG_DLY3    = `PRC_PG_DLY3_MS * `PRC_MS_CYCLES
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_wr_done,
  input  wire       fresh_seal,
  input  wire       seal_break_req,
  input  wire       in_suspend,
  input  wire       wake_from_suspend,
  input  wire       seq_update,
  input  wire [7:0] seq_conv_enables,
  input  wire [7:0] seq_sw_enables,
  input  wire       push_button,
  input  wire       pg_raw,
  input  wire       general_pin_one_in,
  input  wire       general_pin_three_in,
  output reg        general_pin_one_out,
  output reg        general_pin_one_oe,
  output reg        general_output_two,
  output reg        general_output_two_oe,
  output reg        general_output_three,
  output reg        conv_warm_reset,
  output reg  [5:0] converter_enables_out,
  output reg  [3:0] switch_regulator_enables_out,
  output reg        power_good,
  output reg        pb_reset,
  output reg        key_match_seen,
  output reg        seal_break_go,
  output reg        default_program_go,
  output reg  [1:0] power_good_delay,
  output reg        tight_supervision,
  output reg  [1:0] lockout_threshold,
  output reg        lockout_hysteresis,
  output reg  [1:0] switch_three_limit,
  output reg  [1:0] switch_two_limit
);

  localparam [2:0] ST_LOCKED   = 3'b001;
  localparam [2:0] ST_UNLOCKED = 3'b010;
  localparam [2:0] ST_ARMED    = 3'b100;

  reg  [7:0]  rail_suspend_flags;
  reg  [7:0]  converter_enables;
  reg  [7:0]  switch_regulator_output_enables;
  reg  [7:0]  supervisor_pin_config;
  reg  [7:0]  switch_limit_lockout_config;
  reg  [7:0]  susp_snapshot;
  reg  [2:0]  key_state;
  reg  [39:0] pb_count;
  reg  [7:0]  next_converter_enables;
  reg  [7:0]  next_rdata;
  reg  [2:0]  next_key_state;
  wire        wr_prot;
  wire        key_ok;
  wire        pin_one_select;
  wire [7:0]  flag_live;
  wire [39:0] pb_limit;
  wire        pg_delayed;

  assign pin_one_select = supervisor_pin_config[`PRC_BIT_PIN_ONE_SEL];
  assign key_ok         = (key_state == ST_UNLOCKED);
  // Any protected write consumes the unlock, whether or not it lands
  assign wr_prot        = reg_wr && (reg_addr >= `PRC_ADDR_CONV_EN)
                          && (reg_addr <= `PRC_ADDR_CFG2);

  // Live enable states mapped into flag byte order
  assign flag_live = {switch_regulator_output_enables[`PRC_BIT_OUT_THREE],
                      switch_regulator_output_enables[`PRC_BIT_OUT_TWO],
                      switch_regulator_output_enables[`PRC_BIT_OUT_ONE],
                      switch_regulator_output_enables[0],
                      converter_enables[3:0]};

  // Key sequencer: write key, then one protected write; writing key again arms
  always @*
  begin
    next_key_state = key_state;
    case (key_state)
      ST_LOCKED:
        if (reg_wr && reg_addr == `PRC_ADDR_KEY && reg_wdata == KEY_VALUE)
          next_key_state = ST_UNLOCKED;
      ST_UNLOCKED:
        if (reg_wr && reg_addr == `PRC_ADDR_KEY)
          next_key_state = (reg_wdata == KEY_VALUE) ? ST_ARMED : ST_LOCKED;
        else if (wr_prot)
          next_key_state = ST_LOCKED;
      ST_ARMED:
        if (reg_wr)
          next_key_state = ST_LOCKED;
      default:
        next_key_state = ST_LOCKED;
    endcase
  end

  // Backup converters cannot be turned off by a host write while the seal is intact
  always @*
  begin
    next_converter_enables = reg_wdata & `PRC_MASK_CONV_EN;
    if (fresh_seal)
    begin
      if (converter_enables[`PRC_BIT_CONV_FIVE])
        next_converter_enables[`PRC_BIT_CONV_FIVE] = 1'b1;
      if (converter_enables[`PRC_BIT_CONV_SIX])
        next_converter_enables[`PRC_BIT_CONV_SIX] = 1'b1;
    end
  end

  always @*
  begin
    case (reg_addr)
      `PRC_ADDR_SUSPEND_FLAGS: next_rdata = rail_suspend_flags;
      `PRC_ADDR_KEY:           next_rdata = 8'h00;
      `PRC_ADDR_CONV_EN:       next_rdata = converter_enables;
      `PRC_ADDR_SW_EN:         next_rdata = switch_regulator_output_enables;
      `PRC_ADDR_CFG1:          next_rdata = supervisor_pin_config;
      `PRC_ADDR_CFG2:          next_rdata = switch_limit_lockout_config;
      default:                 next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      key_state                       <= ST_LOCKED;
      converter_enables               <= `PRC_RST_CONV_EN;
      switch_regulator_output_enables <= `PRC_RST_SW_EN;
      supervisor_pin_config           <= `PRC_RST_CFG1;
      switch_limit_lockout_config     <= `PRC_RST_CFG2;
      rail_suspend_flags              <= `PRC_RST_SUSPEND_FLAGS;
      susp_snapshot                   <= 8'h00;
      reg_rdata                       <= 8'h00;
      reg_wr_done                     <= 1'b0;
      key_match_seen                  <= 1'b0;
      seal_break_go                   <= 1'b0;
      default_program_go              <= 1'b0;
    end
    else
    begin
      key_state          <= next_key_state;
      reg_wr_done        <= reg_wr;
      key_match_seen     <= key_ok;
      seal_break_go      <= key_ok && seal_break_req && !fresh_seal;
      default_program_go <= (key_state == ST_ARMED) && wr_prot;
      if (reg_rd)
        reg_rdata <= next_rdata;
      if (in_suspend)
        susp_snapshot <= flag_live;
      // Power-up from off leaves reset zeros; only a suspend wake loads flags
      if (wake_from_suspend)
        rail_suspend_flags <= susp_snapshot;
      // Sequencer has priority over a host write in the same cycle
      if (seq_update)
      begin
        converter_enables <= (converter_enables & ~`PRC_SEQ_CONV_MASK)
                             | (seq_conv_enables & `PRC_SEQ_CONV_MASK);
        switch_regulator_output_enables <=
          (switch_regulator_output_enables & ~`PRC_SEQ_SW_MASK)
          | (seq_sw_enables & `PRC_SEQ_SW_MASK);
      end
      else if (wr_prot && key_ok)
      begin
        case (reg_addr)
          `PRC_ADDR_CONV_EN:
            converter_enables <= next_converter_enables;
          `PRC_ADDR_SW_EN:
            switch_regulator_output_enables <= reg_wdata & `PRC_MASK_SW_EN;
          `PRC_ADDR_CFG1:
            supervisor_pin_config <= reg_wdata & `PRC_MASK_CFG1;
          `PRC_ADDR_CFG2:
            switch_limit_lockout_config <= reg_wdata & `PRC_MASK_CFG2;
          default:
            key_state <= next_key_state;
        endcase
      end
    end
  end

  // Pins and rail outputs, all registered
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      general_pin_one_out          <= 1'b0;
      general_pin_one_oe           <= 1'b1;
      general_output_two           <= 1'b0;
      general_output_two_oe        <= 1'b1;
      general_output_three         <= 1'b0;
      conv_warm_reset              <= 1'b0;
      converter_enables_out        <= 6'h00;
      switch_regulator_enables_out <= 4'h0;
      power_good_delay             <= 2'b01;
      tight_supervision            <= 1'b0;
      lockout_threshold            <= 2'b00;
      lockout_hysteresis           <= 1'b1;
      switch_three_limit           <= 2'b00;
      switch_two_limit             <= 2'b00;
    end
    else
    begin
      converter_enables_out        <= converter_enables[5:0];
      switch_regulator_enables_out <= switch_regulator_output_enables[3:0];
      if (pin_one_select)
      begin
        // Pin one is an input steering output two as memory reset
        general_pin_one_out <= 1'b0;
        general_pin_one_oe  <= 1'b0;
        general_output_two  <= general_pin_one_in;
      end
      else
      begin
        // Open drain: drive only the low level
        general_pin_one_out <= 1'b0;
        general_pin_one_oe  <= ~switch_regulator_output_enables[`PRC_BIT_OUT_ONE];
        general_output_two  <= switch_regulator_output_enables[`PRC_BIT_OUT_TWO];
      end
      // Open-drain two drives only when low; push-pull always drives
      if (supervisor_pin_config[`PRC_BIT_OUT_TWO_BUF])
        general_output_two_oe <= 1'b1;
      else
        general_output_two_oe <= pin_one_select ? ~general_pin_one_in
                                 : ~switch_regulator_output_enables[`PRC_BIT_OUT_TWO];
      if (switch_limit_lockout_config[`PRC_BIT_WARM_RESET])
      begin
        conv_warm_reset      <= general_pin_three_in;
        general_output_three <= 1'b0;
      end
      else
      begin
        conv_warm_reset      <= 1'b0;
        general_output_three <= switch_regulator_output_enables[`PRC_BIT_OUT_THREE];
      end
      power_good_delay   <= supervisor_pin_config[`PRC_BIT_PG_DELAY_HI:`PRC_BIT_PG_DELAY_LO];
      tight_supervision  <= supervisor_pin_config[`PRC_BIT_SENSITIVITY];
      lockout_threshold  <= supervisor_pin_config[`PRC_BIT_UVLO_HI:`PRC_BIT_UVLO_LO];
      lockout_hysteresis <= switch_limit_lockout_config[`PRC_BIT_HYSTERESIS];
      switch_three_limit <= switch_limit_lockout_config[3:2];
      switch_two_limit   <= switch_limit_lockout_config[1:0];
    end
  end

  // Push-button hold timer; long presses here can run for seconds
  assign pb_limit = supervisor_pin_config[`PRC_BIT_RESET_TIME] ? PB_LONG : PB_SHORT;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pb_count <= 40'h00_0000_0000;
      pb_reset <= 1'b0;
    end
    else if (!push_button)
    begin
      pb_count <= 40'h00_0000_0000;
      pb_reset <= 1'b0;
    end
    else if (pb_count + 40'h00_0000_0001 >= pb_limit)
      pb_reset <= 1'b1;
    else
      pb_count <= pb_count + 40'h00_0000_0001;
  end

  prc_pg_delay #(
    .DLY0 (PG_DLY0),
    .DLY1 (PG_DLY1),
    .DLY2 (PG_DLY2),
    .DLY3 (PG_DLY3)
  ) u_pg_delay (
    .clk       (clk),
    .rst_b     (rst_b),
    .delay_sel (supervisor_pin_config[`PRC_BIT_PG_DELAY_HI:`PRC_BIT_PG_DELAY_LO]),
    .pg_raw    (pg_raw),
    .pg_out    (pg_delayed)
  );

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      power_good <= 1'b0;
    else
      power_good <= pg_delayed;
  end

endmodule // prc_rail_ctrl

// *** rtl/prc_regs.vh ***
// Purpose: Offsets, field positions, reset values and timing counts of the rail control bank
// Assumes: 8-bit subaddressed register access, 100 MHz core clock
// Notes:   Definitions only
`ifndef PRC_REGS_VH
`define PRC_REGS_VH

`define PRC_ADDR_SUSPEND_FLAGS   8'h07
`define PRC_ADDR_KEY             8'h10
`define PRC_ADDR_CONV_EN         8'h11
`define PRC_ADDR_SW_EN           8'h12
`define PRC_ADDR_CFG1            8'h13
`define PRC_ADDR_CFG2            8'h14

`define PRC_RST_SUSPEND_FLAGS    8'h00
`define PRC_RST_CONV_EN          8'h00
`define PRC_RST_SW_EN            8'h00
`define PRC_RST_CFG1             8'h08
`define PRC_RST_CFG2             8'hc0

`define PRC_MASK_CONV_EN         8'h3f
`define PRC_MASK_SW_EN           8'h7f
`define PRC_MASK_CFG1            8'hff
`define PRC_MASK_CFG2            8'hcf
`define PRC_SEQ_CONV_MASK        8'h1f
`define PRC_SEQ_SW_MASK          8'h03

`define PRC_KEY_VALUE            8'h7d

`define PRC_BIT_CONV_FIVE        4
`define PRC_BIT_CONV_SIX         5
`define PRC_BIT_OUT_ONE          4
`define PRC_BIT_OUT_TWO          5
`define PRC_BIT_OUT_THREE        6
`define PRC_BIT_RESET_TIME       7
`define PRC_BIT_OUT_TWO_BUF      6
`define PRC_BIT_PIN_ONE_SEL      5
`define PRC_BIT_PG_DELAY_HI      4
`define PRC_BIT_PG_DELAY_LO      3
`define PRC_BIT_SENSITIVITY      2
`define PRC_BIT_UVLO_HI          1
`define PRC_BIT_UVLO_LO          0
`define PRC_BIT_WARM_RESET       7
`define PRC_BIT_HYSTERESIS       6

`define PRC_CLK_HZ               100000000
`define PRC_PB_SHORT_S           8
`define PRC_PB_LONG_S            15
`define PRC_PG_DLY0_MS           10
`define PRC_PG_DLY1_MS           20
`define PRC_PG_DLY2_MS           50
`define PRC_PG_DLY3_MS           150
`define PRC_MS_CYCLES            (`PRC_CLK_HZ / 1000)

`endif

// *** testbench/prc_host_model.sv ***
// Purpose: Host controller model driving subaddressed register cycles
// Assumes: one-cycle strobes taken at the rising edge
// Notes:   Released address and data lines show inverted values
`timescale 1ns/10ps
module prc_host_model #(
  parameter [7:0] KEY_VALUE = 8'h7d
) (
  input  wire       clk,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata
);
  initial
  begin
    {reg_wr, reg_rd} = 2'h0;
    {reg_addr, reg_wdata} = 16'h0000;
  end
  task cyc(input logic w, input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'h0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  end
  endtask
  // Key opens exactly one protected write
  task pwr(input [7:0] a, input [7:0] d);
  begin
    cyc(1'b1, 8'h10, KEY_VALUE);
    cyc(1'b1, a, d);
  end
  endtask
endmodule // prc_host_model

// *** testbench/prc_rail_ctrl_checker.sv ***
// Purpose: Assertions on the rail control register bank ports
// Assumes: read data lands one cycle after the read strobe
// Notes:   Bound to every prc_rail_ctrl instance
`timescale 1ns/10ps
module prc_rail_ctrl_checker (
  input wire       clk,
  input wire       rst_b,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire       seq_update,
  input wire [7:0] seq_conv_enables,
  input wire [5:0] converter_enables_out,
  input wire       pg_raw,
  input wire       power_good,
  input wire       push_button,
  input wire       pb_reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_key_zero; reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00; endproperty
  a_key_zero: assert property (p_key_zero) else $error("key read not zero");
  property p_conv_rsv; reg_rd && reg_addr == 8'h11 |=> reg_rdata[7:6] == 2'h0; endproperty
  a_conv_rsv: assert property (p_conv_rsv) else $error("conv reserved set");
  property p_sw_rsv; reg_rd && reg_addr == 8'h12 |=> !reg_rdata[7]; endproperty
  a_sw_rsv: assert property (p_sw_rsv) else $error("switch_regulator_output_enables reserved set");
  property p_cfg2_rsv; reg_rd && reg_addr == 8'h14 |=> reg_rdata[5:4] == 2'h0; endproperty
  a_cfg2_rsv: assert property (p_cfg2_rsv) else $error("switch_limit_lockout_config reserved set");
  property p_seq;
    seq_update |-> ##2 converter_enables_out[4:0] == $past(seq_conv_enables[4:0], 2);
  endproperty
  a_seq: assert property (p_seq) else $error("sequencer update lost");
  // Shortest selectable delay is above eight cycles in the bench
  property p_pg_hold; $rose(pg_raw) && !power_good |=> !power_good [*8]; endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("power good rose early");
  property p_pg_fall; $fell(pg_raw) |-> ##[1:2] !power_good; endproperty
  a_pg_fall: assert property (p_pg_fall) else $error("power good fall delayed");
  property p_pb; $rose(pb_reset) |-> push_button && $past(push_button, 8); endproperty
  a_pb: assert property (p_pb) else $error("reset without held button");
  c_key: cover property (reg_rd && reg_addr == 8'h10);
  c_pg: cover property ($rose(power_good));
  c_pb: cover property ($rose(pb_reset));
endmodule // prc_rail_ctrl_checker

bind prc_rail_ctrl prc_rail_ctrl_checker i_prc_rail_ctrl_checker (.clk, .rst_b, .reg_rd,
  .reg_addr, .reg_rdata, .seq_update, .seq_conv_enables, .converter_enables_out, .pg_raw,
  .power_good, .push_button, .pb_reset);

// *** testbench/prc_rail_ctrl_tb.sv ***
// Purpose: Self-checking bench for the rail control register bank
// Assumes: shortened push-button and power-good counts
// Notes:   Reads queue their expected byte; a monitor compares it
`timescale 1ns/10ps
module prc_rail_ctrl_tb;
  logic        clk, rst_b, fresh_seal, in_suspend, wake_from_suspend, seq_update;
  logic        push_button, pg_raw, pin1, pin3, rd_pend, seal_break_req;
  logic  [7:0] seq_c, seq_s, d, c1;
  wire         reg_wr, reg_rd, general_output_two, general_output_two_oe, general_pin_one_oe;
  wire         conv_warm_reset, power_good, pb_reset, tight_supervision, lockout_hysteresis;
  wire         general_output_three, key_match_seen, seal_break_go, default_program_go;
  wire   [5:0] converter_enables_out;
  wire   [3:0] switch_regulator_enables_out;
  wire   [7:0] reg_addr, reg_wdata, reg_rdata;
  wire   [1:0] power_good_delay, lockout_threshold, switch_three_limit, switch_two_limit;
  wire   [9:0] cfg_o = {lockout_hysteresis, tight_supervision, power_good_delay,
                        lockout_threshold, switch_three_limit, switch_two_limit};
  logic [15:0] exp_q[$];
  int          fail_count, compares, i, r;
  // Shortened hold and delay counts keep the run brief
  localparam [39:0] PB_SHORT_CYC = 40'h00_0000_0028;
  localparam [39:0] PB_LONG_CYC  = 40'h00_0000_004b;
  localparam [31:0] PG_CYC0      = 32'h0000_000a;
  localparam [31:0] PG_CYC1      = 32'h0000_0014;
  localparam [31:0] PG_CYC2      = 32'h0000_0032;
  localparam [31:0] PG_CYC3      = 32'h0000_0096;
  int          dly [0:3] = '{PG_CYC0, PG_CYC1, PG_CYC2, PG_CYC3};
  logic  [7:0] ra [0:6] = '{8'h07, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
  logic  [7:0] rv [0:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'hc0, 8'h00};

  prc_rail_ctrl #(.PB_SHORT(PB_SHORT_CYC), .PB_LONG(PB_LONG_CYC), .PG_DLY0(PG_CYC0),
    .PG_DLY1(PG_CYC1), .PG_DLY2(PG_CYC2), .PG_DLY3(PG_CYC3)) i_prc_rail_ctrl (.clk, .rst_b,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr_done(), .fresh_seal,
    .seal_break_req, .in_suspend, .wake_from_suspend, .seq_update, .seq_conv_enables(seq_c),
    .seq_sw_enables(seq_s), .push_button, .pg_raw, .general_pin_one_in(pin1),
    .general_pin_three_in(pin3), .general_pin_one_out(), .general_pin_one_oe,
    .general_output_two, .general_output_two_oe, .general_output_three, .conv_warm_reset,
    .converter_enables_out, .switch_regulator_enables_out, .power_good, .pb_reset,
    .key_match_seen, .seal_break_go, .default_program_go, .power_good_delay,
    .tight_supervision, .lockout_threshold, .lockout_hysteresis, .switch_three_limit,
    .switch_two_limit);
  prc_host_model i_prc_host_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  task chk(input string n, input [15:0] e, input [15:0] s);
  begin
    compares = compares + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task rc(input [7:0] a, input [7:0] e);
  begin
    exp_q.push_back({8'h00, e});
    i_prc_host_model.cyc(1'b0, a, 8'h00);
  end
  endtask
  // Lets registered outputs land before sampling
  task wt(input int n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task print_verdict;
  begin
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  always @(posedge clk)
  begin
    if (rd_pend)
      chk("reg_rdata", exp_q.pop_front(), {8'h00, reg_rdata});
    rd_pend <= reg_rd;
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is near seven hundred cycles
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    print_verdict;
  end
  initial
  begin
    {rst_b, fresh_seal, in_suspend, wake_from_suspend, seq_update} = 5'h00;
    {push_button, pg_raw, pin1, pin3, seal_break_req} = 5'h00;
    {seq_c, seq_s} = 16'h0000;
    fail_count = 0;
    compares = 0;
    r = $urandom(32'he35a_c55d);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i++)
      rc(ra[i], rv[i]);
    r = $urandom;
    // A random byte must never hit the key by chance
    i_prc_host_model.cyc(1'b1, 8'h10, (r[7:0] == 8'h7d) ? 8'h00 : r[7:0]);
    rc(8'h10, 8'h00);
    i_prc_host_model.cyc(1'b1, 8'h10, 8'h7d);
    seal_break_req <= 1'b1;
    wt(2);
    chk("seal_go", 16'h0003, {14'h0000, key_match_seen, seal_break_go});
    @(posedge clk);
    fresh_seal <= 1'b1;
    wt(2);
    chk("seal_go", 16'h0002, {14'h0000, key_match_seen, seal_break_go});
    @(posedge clk);
    {fresh_seal, seal_break_req} <= 2'h0;
    i_prc_host_model.cyc(1'b1, 8'h10, 8'h00);
    wt(2);
    chk("key_seen", 16'h0000, {15'h0000, key_match_seen});
    // Key twice arms default programming; the following write only pulses it
    i_prc_host_model.cyc(1'b1, 8'h10, 8'h7d);
    i_prc_host_model.pwr(8'h11, 8'h00);
    #1;
    chk("prog_go", 16'h0001, {15'h0000, default_program_go});
    i_prc_host_model.cyc(1'b1, 8'h11, 8'h3f);
    rc(8'h11, 8'h00);
    i_prc_host_model.pwr(8'h11, 8'hff);
    rc(8'h11, 8'h3f);
    fresh_seal <= 1'b1;
    i_prc_host_model.pwr(8'h11, 8'h00);
    rc(8'h11, 8'h30);
    fresh_seal <= 1'b0;
    i_prc_host_model.pwr(8'h11, 8'h00);
    rc(8'h11, 8'h00);
    i_prc_host_model.pwr(8'h12, 8'hff);
    rc(8'h12, 8'h7f);
    for (i = 0; i < 4; i++)
    begin
      r = $urandom;
      c1 = (r[7:0] & 8'he4) | {3'h0, i[1:0], 1'b0, i[1:0]};
      i_prc_host_model.pwr(8'h13, c1);
      rc(8'h13, c1);
      wt(3);
      chk("cfg_o", {6'h00, 1'b1, c1[2], i[1:0], i[1:0], 4'h0}, {6'h00, cfg_o});
    end
    for (i = 0; i < 4; i++)
    begin
      r = $urandom;
      d = {r[7:4], i[1:0], ~i[1:0]};
      pin3 <= r[8];
      i_prc_host_model.pwr(8'h14, d);
      rc(8'h14, d & 8'hcf);
      wt(3);
      chk("cfg_o", {6'h00, d[6], c1[2], c1[4:3], c1[1:0], d[3:0]}, {6'h00, cfg_o});
      chk("warm", {15'h0000, d[7] & pin3}, {15'h0000, conv_warm_reset});
      chk("general_output_three", {15'h0000, !d[7]}, {15'h0000, general_output_three});
    end
    pin1 <= 1'b1;
    i_prc_host_model.pwr(8'h13, 8'h48);
    i_prc_host_model.pwr(8'h12, 8'h20);
    wt(3);
    chk("gpo", 16'h0007, {13'h0000, general_output_two, general_output_two_oe,
        general_pin_one_oe});
    i_prc_host_model.pwr(8'h13, 8'h28);
    i_prc_host_model.pwr(8'h12, 8'h00);
    wt(3);
    chk("gpo", 16'h0002, {14'h0000, general_output_two, general_pin_one_oe});
    i_prc_host_model.pwr(8'h11, 8'h2b);
    i_prc_host_model.pwr(8'h12, 8'h51);
    in_suspend <= 1'b1;
    repeat (4) @(posedge clk);
    wake_from_suspend <= 1'b1;
    @(posedge clk);
    {in_suspend, wake_from_suspend} <= 2'h0;
    rc(8'h07, 8'hbb);
    r = $urandom;
    {seq_c, seq_s} <= r[15:0];
    seq_update <= 1'b1;
    @(posedge clk);
    seq_update <= 1'b0;
    rc(8'h11, {3'h1, r[12:8]});
    rc(8'h12, {6'h14, r[1:0]});
    wt(1);
    chk("rails", {6'h00, 1'b1, r[12:8], 2'h0, r[1:0]},
        {6'h00, converter_enables_out, switch_regulator_enables_out});
    for (i = 0; i < 2; i++)
    begin
      i_prc_host_model.pwr(8'h13, {i[0], 7'h08});
      @(posedge clk);
      push_button <= 1'b1;
      wt(50);
      chk("pb_reset", {15'h0000, !i[0]}, {15'h0000, pb_reset});
      wt(35);
      chk("pb_reset", 16'h0001, {15'h0000, pb_reset});
      @(posedge clk);
      push_button <= 1'b0;
      repeat (5) @(posedge clk);
    end
    for (i = 0; i < 4; i++)
    begin
      i_prc_host_model.pwr(8'h13, {3'h0, i[1:0], 3'h0});
      @(posedge clk);
      pg_raw <= 1'b1;
      wt(dly[i] - 3);
      chk("pgood", 16'h0000, {15'h0000, power_good});
      wt(8);
      chk("pgood", 16'h0001, {15'h0000, power_good});
      @(posedge clk);
      pg_raw <= 1'b0;
      wt(3);
      chk("pgood", 16'h0000, {15'h0000, power_good});
    end
    print_verdict;
  end
endmodule // prc_rail_ctrl_tb
